// ===== verilog/adcc_map.svh
`ifndef ADCC_MAP_SVH
`define ADCC_MAP_SVH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define ADCC_ADDR_CFG      6'h2C
`define ADCC_ADDR_OFS_HI   6'h2D
`define ADCC_ADDR_OFS_LO   6'h2E
`define ADCC_ADDR_GAIN_HI  6'h2F
`define ADCC_ADDR_GAIN_LO  6'h30
`define ADCC_ADDR_CHECKSUM 6'h3E
`define ADCC_ADDR_RSVD     6'h3F

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ADCC_DELAY_HI      15
`define ADCC_DELAY_LO      6
`define ADCC_RSVD_CFG_HI   5
`define ADCC_RSVD_CFG_LO   3
`define ADCC_BYPASS_BIT    2
`define ADCC_SEL_HI        1
`define ADCC_SEL_LO        0
`define ADCC_LOWB_HI       15
`define ADCC_LOWB_LO       8

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ADCC_RST_ZERO16    16'h0000
`define ADCC_RST_GAIN_HI   16'h8000
`define ADCC_RST_ZERO8     8'h00
`define ADCC_RST_DELAY     10'h000
`define ADCC_RST_BYPASS    1'h0

`endif

// ===== verilog/adcc_pkg.sv
package adcc_pkg;

   typedef enum logic [1:0] {
      ADCC_IN_PAIR    = 2'h0,
      ADCC_IN_SHORTED = 2'h1,
      ADCC_IN_TEST_P  = 2'h2,
      ADCC_IN_TEST_N  = 2'h3
   } adcc_insel_e;

   typedef struct packed {
      logic signed [9:0] ch_delay_value;
      logic              ch_highpass_bypass;
      adcc_insel_e       ch_input_select;
   } adcc_cfg_s;

   typedef struct packed {
      logic [15:0] ch_offset_upper;
      logic [7:0]  ch_offset_lower;
      logic [15:0] ch_gain_upper;
      logic [7:0]  ch_gain_lower;
   } adcc_cal_s;

   typedef struct packed {
      logic        wr_en;
      logic        rd_en;
      logic [5:0]  addr;
      logic [15:0] wdata;
   } adcc_req_s;

endpackage : adcc_pkg

// ===== verilog/adcc_ch7_regs.sv
`include "adcc_map.svh"

module adcc_ch7_regs #(
   parameter int ADDR_W = 6,
   parameter int DATA_W = 16
) (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire adcc_pkg::adcc_req_s req,
   input  wire logic [15:0]       crc_value,
   output adcc_pkg::adcc_cfg_s    ch_cfg,
   output adcc_pkg::adcc_cal_s    ch_cal,
   output logic [15:0]            rd_data,
   output logic                   rd_valid
);
   import adcc_pkg::*;

   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   if (ADDR_W != 6 || DATA_W != 16) begin : g_bad_param
      $error("adcc_ch7_regs supports only 6-bit address, 16-bit data");
   end

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   logic        wr_cfg;
   logic        wr_ofs_hi;
   logic        wr_ofs_lo;
   logic        wr_gain_hi;
   logic        wr_gain_lo;
   logic        wr_rsvd;
   logic [15:0] rsvd_word;
   logic [15:0] next_rd_data;

   function automatic logic [15:0] low_word(input logic [7:0] b);
      // upper byte carries the value, lower byte always zero
      low_word = {b, `ADCC_RST_ZERO8};
   endfunction : low_word

   assign wr_cfg     = req.wr_en && req.addr == `ADCC_ADDR_CFG;
   assign wr_ofs_hi  = req.wr_en && req.addr == `ADCC_ADDR_OFS_HI;
   assign wr_ofs_lo  = req.wr_en && req.addr == `ADCC_ADDR_OFS_LO;
   assign wr_gain_hi = req.wr_en && req.addr == `ADCC_ADDR_GAIN_HI;
   assign wr_gain_lo = req.wr_en && req.addr == `ADCC_ADDR_GAIN_LO;
   assign wr_rsvd    = req.wr_en && req.addr == `ADCC_ADDR_RSVD;

   // ----------------------------------------------------------------
   // configuration word
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ch_cfg.ch_delay_value     <= `ADCC_RST_DELAY;
         ch_cfg.ch_highpass_bypass <= `ADCC_RST_BYPASS;
         ch_cfg.ch_input_select    <= ADCC_IN_PAIR;
      end else if (wr_cfg) begin
         ch_cfg.ch_delay_value <=
            req.wdata[`ADCC_DELAY_HI:`ADCC_DELAY_LO];
         ch_cfg.ch_highpass_bypass <= req.wdata[`ADCC_BYPASS_BIT];
         ch_cfg.ch_input_select <=
            adcc_insel_e'(req.wdata[`ADCC_SEL_HI:`ADCC_SEL_LO]);
      end
   end

   // ----------------------------------------------------------------
   // offset and gain calibration, one process for the whole output
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ch_cal.ch_offset_upper <= `ADCC_RST_ZERO16;
         ch_cal.ch_offset_lower <= `ADCC_RST_ZERO8;
         ch_cal.ch_gain_upper   <= `ADCC_RST_GAIN_HI;
         ch_cal.ch_gain_lower   <= `ADCC_RST_ZERO8;
      end else begin
         if (wr_ofs_hi) begin
            ch_cal.ch_offset_upper <= req.wdata;
         end
         if (wr_ofs_lo) begin
            ch_cal.ch_offset_lower <=
               req.wdata[`ADCC_LOWB_HI:`ADCC_LOWB_LO];
         end
         if (wr_gain_hi) begin
            ch_cal.ch_gain_upper <= req.wdata;
         end
         if (wr_gain_lo) begin
            ch_cal.ch_gain_lower <=
               req.wdata[`ADCC_LOWB_HI:`ADCC_LOWB_LO];
         end
      end
   end

   // ----------------------------------------------------------------
   // reserved word
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rsvd_word <= `ADCC_RST_ZERO16;
      end else if (wr_rsvd) begin
         rsvd_word <= req.wdata;
      end
   end

   // ----------------------------------------------------------------
   // read back
   // ----------------------------------------------------------------
   always_comb begin
      next_rd_data = `ADCC_RST_ZERO16;
      unique case (req.addr)
         `ADCC_ADDR_CFG: begin
            next_rd_data[`ADCC_DELAY_HI:`ADCC_DELAY_LO] =
               ch_cfg.ch_delay_value;
            next_rd_data[`ADCC_BYPASS_BIT] = ch_cfg.ch_highpass_bypass;
            next_rd_data[`ADCC_SEL_HI:`ADCC_SEL_LO] =
               ch_cfg.ch_input_select;
         end
         `ADCC_ADDR_OFS_HI:   next_rd_data = ch_cal.ch_offset_upper;
         `ADCC_ADDR_OFS_LO:   next_rd_data = low_word(ch_cal.ch_offset_lower);
         `ADCC_ADDR_GAIN_HI:  next_rd_data = ch_cal.ch_gain_upper;
         `ADCC_ADDR_GAIN_LO:  next_rd_data = low_word(ch_cal.ch_gain_lower);
         `ADCC_ADDR_CHECKSUM: next_rd_data = crc_value;
         `ADCC_ADDR_RSVD:     next_rd_data = rsvd_word;
         default:             next_rd_data = `ADCC_RST_ZERO16;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rd_data  <= `ADCC_RST_ZERO16;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= req.rd_en;
         if (req.rd_en) begin
            rd_data <= next_rd_data;
         end
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   property p_delay_write;
      wr_cfg |=> ch_cfg.ch_delay_value ==
         $past(req.wdata[`ADCC_DELAY_HI:`ADCC_DELAY_LO]);
   endproperty
   a_delay_write: assert property (p_delay_write)
      else $error("delay field not taken from write");

   property p_bypass_hold;
      !wr_cfg |=> $stable(ch_cfg.ch_highpass_bypass);
   endproperty
   a_bypass_hold: assert property (p_bypass_hold)
      else $error("bypass changed without a config write");

   property p_select_write;
      wr_cfg |=> ch_cfg.ch_input_select ==
         $past(req.wdata[`ADCC_SEL_HI:`ADCC_SEL_LO]);
   endproperty
   a_select_write: assert property (p_select_write)
      else $error("input select not taken from write");

   property p_offset_readback;
      wr_ofs_hi ##1 (req.rd_en && req.addr == `ADCC_ADDR_OFS_HI && !wr_ofs_hi)
         |=> rd_valid && rd_data == $past(req.wdata, 2);
   endproperty
   a_offset_readback: assert property (p_offset_readback)
      else $error("offset upper readback differs from write");

   property p_offset_low;
      wr_ofs_lo |=> ch_cal.ch_offset_lower ==
         $past(req.wdata[`ADCC_LOWB_HI:`ADCC_LOWB_LO]);
   endproperty
   a_offset_low: assert property (p_offset_low)
      else $error("offset lower byte not stored");

   property p_gain_reset;
      $rose(rst_n) |-> ch_cal.ch_gain_upper == `ADCC_RST_GAIN_HI &&
         ch_cal.ch_offset_upper == `ADCC_RST_ZERO16;
   endproperty
   a_gain_reset: assert property (p_gain_reset)
      else $error("reset values wrong after release");

   property p_low_rsvd_zero;
      req.rd_en && (req.addr == `ADCC_ADDR_GAIN_LO ||
         req.addr == `ADCC_ADDR_OFS_LO) |=> rd_data[7:0] == 8'h00;
   endproperty
   a_low_rsvd_zero: assert property (p_low_rsvd_zero)
      else $error("reserved low byte read nonzero");

   property p_checksum_read;
      req.rd_en && req.addr == `ADCC_ADDR_CHECKSUM && !req.wr_en
         |=> rd_valid && rd_data == $past(crc_value);
   endproperty
   a_checksum_read: assert property (p_checksum_read)
      else $error("checksum read does not show crc input");

   property p_checksum_nowrite;
      req.wr_en && req.addr == `ADCC_ADDR_CHECKSUM
         |=> $stable(ch_cfg) && $stable(ch_cal) && $stable(rsvd_word);
   endproperty
   a_checksum_nowrite: assert property (p_checksum_nowrite)
      else $error("write to checksum altered a register");

   property p_cfg_rsvd_zero;
      req.rd_en && req.addr == `ADCC_ADDR_CFG
         |=> rd_data[`ADCC_RSVD_CFG_HI:`ADCC_RSVD_CFG_LO] == 3'h0;
   endproperty
   a_cfg_rsvd_zero: assert property (p_cfg_rsvd_zero)
      else $error("reserved config bits read nonzero");

   property p_unmapped_zero;
      req.rd_en && req.addr == 6'h31 |=> rd_valid && rd_data == 16'h0000;
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero)
      else $error("unmapped address read nonzero");

endmodule : adcc_ch7_regs

// ===== tb/adcc_host.sv
module adcc_host (
   input  wire logic          clk,
   output adcc_pkg::adcc_req_s req,
   input  wire logic [15:0]   rd_data,
   input  wire logic          rd_valid
);
   timeunit 1ns;
   timeprecision 1ns;
   import adcc_pkg::*;

   initial req = '0;

   // ----------------------------------------------------------------
   // register port cycles
   // ----------------------------------------------------------------
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      logic [15:0] dd;
      dd = (a == 6'h3F) ? 16'h0000 : d;
      @(posedge clk);
      req <= '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: dd};
      @(posedge clk);
      // released lines show the inverse, not a stale copy
      req <= '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: ~dd};
      #1;
   endtask : wr

   task automatic rd(input  logic [5:0]  a,
                     output logic [15:0] d,
                     output logic        v);
      @(posedge clk);
      req <= '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: req.wdata};
      @(posedge clk);
      req <= '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: ~req.wdata};
      #1;
      d = rd_data;
      v = rd_valid;
   endtask : rd

   // write on one edge, read the same word on the next
   task automatic wr_rd(input  logic [5:0]  a,
                        input  logic [15:0] d,
                        output logic [15:0] q,
                        output logic        v);
      @(posedge clk);
      req <= '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      req <= '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: d};
      @(posedge clk);
      req <= '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: ~d};
      #1;
      q = rd_data;
      v = rd_valid;
   endtask : wr_rd
endmodule : adcc_host

// ===== tb/adcc_ch7_regs_tb.sv
module adcc_ch7_regs_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import adcc_pkg::*;

   logic        clk       = 1'b0;
   logic        rst_n     = 1'b0;
   logic [15:0] crc_value = 16'h0000;
   adcc_req_s   req;
   adcc_cfg_s   ch_cfg;
   adcc_cal_s   ch_cal;
   logic [15:0] rd_data;
   logic        rd_valid;
   logic [15:0] mdl [0:63];
   logic [5:0]  addrs [0:8] = '{6'h2C, 6'h2D, 6'h2E, 6'h2F, 6'h30,
                                6'h3E, 6'h3F, 6'h31, 6'h00};
   int          error_cnt    = 0;
   int          total_checks = 0;

   always #50 clk = ~clk;

   adcc_ch7_regs dut (.clk(clk), .rst_n(rst_n), .req(req),
      .crc_value(crc_value), .ch_cfg(ch_cfg), .ch_cal(ch_cal),
      .rd_data(rd_data), .rd_valid(rd_valid));

   adcc_host host (.clk(clk), .req(req), .rd_data(rd_data),
      .rd_valid(rd_valid));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [15:0] keep_mask(input logic [5:0] a);
      case (a)
         6'h2C:               return 16'hFFC7;
         6'h2D, 6'h2F, 6'h3F: return 16'hFFFF;
         6'h2E, 6'h30:        return 16'hFF00;
         default:             return 16'h0000;
      endcase
   endfunction : keep_mask

   task automatic check(input logic [47:0] seen, exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t %s seen %h expected %h",
                  $time, what, seen, exp);
      end
   endtask : check

   task automatic check_outs();
      check(48'(ch_cfg), 48'({mdl[6'h2C][15:6], mdl[6'h2C][2],
            mdl[6'h2C][1:0]}), "config outputs");
      check(ch_cal, {mdl[6'h2D], mdl[6'h2E][15:8], mdl[6'h2F],
            mdl[6'h30][15:8]}, "calibration outputs");
   endtask : check_outs

   task automatic rd_chk(input logic [5:0] a);
      logic [15:0] got;
      logic        vld;
      host.rd(a, got, vld);
      check(48'(vld), 48'h1, "read valid");
      check(48'(got), 48'(a == 6'h3E ? crc_value : mdl[a]),
            "read data");
      @(posedge clk);
      #1;
      check(48'(rd_valid), 48'h0, "read valid pulse length");
   endtask : rd_chk

   task automatic b2b_chk(input logic [5:0] a, input logic [15:0] d);
      logic [15:0] got;
      logic        vld;
      host.wr_rd(a, d, got, vld);
      mdl[a] = d & keep_mask(a);
      check(48'({vld, got}), 48'({1'b1, mdl[a]}), "write then read");
      check_outs();
   endtask : b2b_chk

   task automatic wr_upd(input logic [5:0] a, input logic [15:0] d);
      host.wr(a, d);
      mdl[a] = (a == 6'h3F) ? 16'h0000 : (d & keep_mask(a));
      check_outs();
      rd_chk(a);
   endtask : wr_upd

   task automatic do_reset();
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 64; i++) mdl[i] = 16'h0000;
      mdl[6'h2F] = 16'h8000;
      #1;
      check_outs();
      check(48'({rd_valid, rd_data}), 48'h0, "read port reset");
   endtask : do_reset

   task automatic finish_test();
      if (error_cnt == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : finish_test

   // ----------------------------------------------------------------
   // test sequence
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(32'h6165));
      do_reset();
      @(posedge clk);
      crc_value <= 16'($urandom);
      for (int a = 0; a < 64; a++) rd_chk(6'(a));
      // all-ones corner: reserved bits must drop
      for (int i = 0; i < 9; i++) wr_upd(addrs[i], 16'hFFFF);
      for (int i = 0; i < 4; i++) begin
         wr_upd(6'h2C, {10'h200, 1'(i), 3'h7, 2'(i)});
         check(48'(ch_cfg.ch_input_select),
               48'(adcc_insel_e'(i)), "input select");
      end
      // write then read on consecutive edges
      for (int i = 0; i < 10; i++) b2b_chk(addrs[i % 5], 16'($urandom));
      repeat (60) wr_upd(addrs[$urandom_range(0, 8)], 16'($urandom));
      // second reset in mid-run
      do_reset();
      for (int i = 0; i < 9; i++) rd_chk(addrs[i]);
      finish_test();
   end

   initial begin
      #500_000;
      error_cnt++;
      finish_test();
   end
endmodule : adcc_ch7_regs_tb
